// ### rcfg_params.svh
// Purpose: offsets, field positions, reset values and limits for rcfg
// Assumes: included by its bare name
// Notes: byte offsets of one aligned 32-bit word each
`ifndef RCFG_PARAMS_SVH
`define RCFG_PARAMS_SVH
`define RCFG_OFF_CMD 8'h00
`define RCFG_OFF_STATUS 8'h04
`define RCFG_OFF_RETRY 8'h08
`define RCFG_OFF_RSSI 8'h0C
`define RCFG_OFF_RESP 8'h10
`define RCFG_OFF_TXFREQ 8'h14
`define RCFG_OFF_RXFREQ 8'h18
`define RCFG_OFF_RXDLY 8'h1C
`define RCFG_OFF_RXIDLE 8'h20
`define RCFG_OFF_SKIP 8'h24
`define RCFG_OFF_SLEEP 8'h28
`define RCFG_OFF_UNIT 8'h2C
`define RCFG_OFF_EXTADR 8'h30
`define RCFG_OFF_PERMIT 8'h34
`define RCFG_OFF_PRIM 8'h38
`define RCFG_OFF_ALARM 8'h3C
`define RCFG_CMD_SETUP 0
`define RCFG_CMD_QUIT 1
`define RCFG_CMD_KEY 2
`define RCFG_CMD_RELEASE 3
`define RCFG_NA_BIT 31
`define RCFG_EN_BIT 16
`define RCFG_RETRY_MAX 4'hA
`define RCFG_RETRY_RST 4'hA
`define RCFG_RSSI_STRONG 8'h28
`define RCFG_RSSI_WEAK 8'h78
`define RCFG_RESP_MAX 7'h50
`define RCFG_FREQ_MIN 20'hDC438
`define RCFG_FREQ_MAX 20'hE2838
`define RCFG_FREQ_RST 20'hDF638
`define RCFG_RXDLY_MAX 8'hEB
`define RCFG_RXIDLE_MAX 11'h5A0
`define RCFG_UNIT_MIN 16'h2710
`define RCFG_UNIT_MAX 16'hFDE8
`define RCFG_EXTADR_MAX 5'h1F
`define RCFG_SETUP_MIN 8'h0A
`define RCFG_KEY_MIN 8'h05
`define RCFG_CLK_MHZ 200
`define RCFG_MINUTE_S 60
`endif

// ### rcfg_pkg.sv
// Purpose: shared types of the radio configuration controller
// Assumes: nothing
// Notes: constants live in rcfg_params.svh
package rcfg_pkg;
   typedef enum logic [1:0] {
      RCFG_ROLE_REMOTE = 2'h0,
      RCFG_ROLE_MASTER = 2'h1,
      RCFG_ROLE_EXT = 2'h2
   } rcfg_role_t;
   typedef enum logic [2:0] {
      RCFG_ST_NORMAL = 3'h1,
      RCFG_ST_SETUP = 3'h2,
      RCFG_ST_KEYED = 3'h4
   } rcfg_state_t;
endpackage

// ### rcfg_top.sv
// Purpose: configuration, status and setup test controller of a radio
// Assumes: AHB-Lite slave, zero wait states, one clock hclk at 200 MHz
// Notes: register values are presented to the hopping and data logic
// Function
// - retry count 0..10, default 10
// - retry zero means no retransmission
// - retry written by master, read synced remote
// - signal strength clamped to -40..-120 dBm
// - remote averages eight zone strengths per sync
// - independent master outside setup reports not available
// - dependent master outside setup reports only while synchronized
// - test responder on/off, address 0..80
// - transmit, receive test frequencies, 902.2..927.8 MHz
// - receive data delay 0..235 ms, off clears
// - inactivity alarm after 0..1440 minutes, default none
// - setup stops hopping, tests frequencies, keying
// - keyed transmitter released after fixed minutes
// - setup ends on quit or ten minutes
// - skip none or up to four zones
// - remote skip read-only, shown while synchronized
// - eight 3.2 MHz zones from 902.2 MHz
// - sleep default off, refused for master/extension
// - alarm report code, class, next per read
// - unit address only 10000..65000
// - extended address 0..31, master/extension only
// - 32-bit permit mask gates synchronization sources
// - no primary source: any permitted source
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rcfg_params.svh"
module rcfg_top #(
   parameter logic [63:0] MINUTE_CYCLES =
      64'(`RCFG_CLK_MHZ) * 64'd1000000 * 64'(`RCFG_MINUTE_S),
   parameter logic [31:0] MAJOR_MASK = 32'h0000_1717
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [1:0] role,
   input wire logic dependent,
   input wire logic synced,
   input wire logic sync_msg,
   input wire logic [2:0] sync_zone,
   input wire logic [7:0] sync_loss,
   input wire logic [7:0] raw_loss,
   input wire logic rx_packet,
   input wire logic [31:0] alarm_in,
   input wire logic [4:0] source_addr,
   output logic source_permitted,
   output logic hop_disable,
   output logic tx_key,
   output logic [19:0] tx_freq_khz,
   output logic [19:0] rx_freq_khz,
   output logic [3:0] retry_count,
   output logic retry_enable,
   output logic [7:0] rxd_delay_ms,
   output logic [7:0] skip_mask,
   output logic sleep_enable,
   output logic [7:0] responder_addr,
   output logic responder_on,
   output logic rx_timeout_alarm
);
   // walk from start upward, first set alarm: {found, code}
   function automatic logic [5:0] rcfg_find(input logic [31:0] v,
                                            input logic [4:0] start);
      logic [5:0] r;
      logic [4:0] idx;
      r = 6'h00;
      for (int i = 31; i >= 0; i--) begin
         idx = 5'(start + 5'(i));
         if (v[idx]) begin
            r = {1'b1, idx};
         end
      end
      return r;
   endfunction

   // zone digit check: 0 empty, 1..8 legal
   function automatic logic rcfg_digit_ok(input logic [3:0] d);
      return d <= 4'h8;
   endfunction

   localparam logic [7:0] SETUP_MIN = `RCFG_SETUP_MIN;
   localparam logic [7:0] KEY_MIN = `RCFG_KEY_MIN;

   rcfg_pkg::rcfg_state_t state, next_state;
   logic [31:0] alarm_vec;
   logic [4:0] alarm_ptr;
   logic ph_write, ph_valid;
   logic [7:0] ph_addr;
   logic [3:0] retry;
   logic [7:0] resp;
   logic [19:0] txf, rxf;
   logic [8:0] rxdly;
   logic [16:0] rxidle;
   logic [15:0] skip_digits;
   logic sleep;
   logic [15:0] unit;
   logic [4:0] extadr;
   logic [31:0] permit;
   logic [5:0] prim;
   logic [7:0] zone_loss [8];
   logic [7:0] rssi;
   logic [63:0] prescale;
   logic [10:0] idle_min;
   logic [7:0] setup_min, key_min;
   logic rejected;

   // role and access decode
   wire is_master = role == rcfg_pkg::RCFG_ROLE_MASTER;
   wire is_ext = role == rcfg_pkg::RCFG_ROLE_EXT;
   wire is_remote = !is_master && !is_ext;
   wire in_setup = state != rcfg_pkg::RCFG_ST_NORMAL;
   wire accept = hsel && hready && htrans[1];
   wire wr = ph_valid && ph_write;
   wire [31:0] wd = hwdata;
   wire minute = prescale == MINUTE_CYCLES - 64'd1;
   wire cmd_wr = wr && ph_addr == `RCFG_OFF_CMD;

   // range and role checks for each writable register; permit, primary and command are always accepted
   wire retry_ok = is_master && wd[3:0] <= `RCFG_RETRY_MAX;
   wire resp_ok = !wd[`RCFG_EN_BIT] || wd[6:0] <= `RCFG_RESP_MAX;
   wire freq_ok = wd[19:0] >= `RCFG_FREQ_MIN &&
                  wd[19:0] <= `RCFG_FREQ_MAX;
   wire rxdly_ok = wd[7:0] <= `RCFG_RXDLY_MAX;
   wire rxidle_ok = wd[10:0] <= `RCFG_RXIDLE_MAX;
   wire skip_ok = !is_remote && rcfg_digit_ok(wd[3:0]) &&
                  rcfg_digit_ok(wd[7:4]) && rcfg_digit_ok(wd[11:8]) &&
                  rcfg_digit_ok(wd[15:12]);
   wire sleep_ok = !(wd[0] && !is_remote);
   wire unit_ok = wd[15:0] >= `RCFG_UNIT_MIN &&
                  wd[15:0] <= `RCFG_UNIT_MAX;
   wire extadr_ok = !is_remote && wd[4:0] <= `RCFG_EXTADR_MAX;
   wire [7:0] a = ph_addr;
   wire write_ok =
      (a == `RCFG_OFF_RETRY) ? retry_ok :
      (a == `RCFG_OFF_RESP) ? resp_ok :
      (a == `RCFG_OFF_TXFREQ || a == `RCFG_OFF_RXFREQ) ? freq_ok :
      (a == `RCFG_OFF_RXDLY) ? rxdly_ok :
      (a == `RCFG_OFF_RXIDLE) ? rxidle_ok :
      (a == `RCFG_OFF_SKIP) ? skip_ok :
      (a == `RCFG_OFF_SLEEP) ? sleep_ok :
      (a == `RCFG_OFF_UNIT) ? unit_ok :
      (a == `RCFG_OFF_EXTADR) ? extadr_ok :
      (a == `RCFG_OFF_PERMIT || a == `RCFG_OFF_PRIM ||
       a == `RCFG_OFF_CMD) ? 1'b1 : 1'b0;
   wire do_wr = wr && write_ok;

   // zone skip mask from stored digits
   logic [7:0] next_skip_mask;
   always_comb begin
      next_skip_mask = 8'h00;
      for (int i = 0; i < 4; i++) begin
         if (skip_digits[i*4 +: 4] != 4'h0) begin
            next_skip_mask[3'(skip_digits[i*4 +: 4] - 4'h1)] = 1'b1;
         end
      end
   end

   // eight-zone average of the last sync strengths, clamped
   logic [10:0] zone_sum;
   always_comb begin
      zone_sum = 11'h000;
      for (int i = 0; i < 8; i++) begin
         zone_sum = zone_sum + 11'(zone_loss[i]);
      end
   end
   wire [7:0] avg_loss = zone_sum[10:3];
   wire [7:0] src_loss = in_setup ? raw_loss : avg_loss;
   wire [7:0] clamp_loss =
      src_loss < `RCFG_RSSI_STRONG ? `RCFG_RSSI_STRONG :
      src_loss > `RCFG_RSSI_WEAK ? `RCFG_RSSI_WEAK : src_loss;
   wire rssi_na = !in_setup && ((is_master && !dependent) ||
                  (is_master && dependent && !synced));
   wire remote_na = is_remote && !synced;

   // alarm walk: one code per read, wrapping
   wire [5:0] found = rcfg_find(alarm_vec, alarm_ptr);
   wire [4:0] after = 5'(found[4:0] + 5'h01);
   wire [5:0] further = rcfg_find(alarm_vec & ~(32'h1 << found[4:0]),
                                  after);
   wire [31:0] alarm_word = found[5] ?
      {1'b1, 21'h0, further[5], MAJOR_MASK[found[4:0]], 3'h0, found[4:0]}
      : 32'h0000_0000;

   // read mux, sampled in the address phase
   wire [7:0] ra = haddr;
   wire [31:0] rd =
      (ra == `RCFG_OFF_STATUS) ? {27'h0, rejected, rx_timeout_alarm,
                                  state == rcfg_pkg::RCFG_ST_KEYED,
                                  in_setup, synced} :
      (ra == `RCFG_OFF_RETRY) ? (remote_na ? 32'h8000_0000 :
                                 {28'h0, retry}) :
      (ra == `RCFG_OFF_RSSI) ? (rssi_na ? 32'h8000_0000 :
                                {24'h0, rssi}) :
      (ra == `RCFG_OFF_RESP) ? {15'h0, resp[7], 9'h0, resp[6:0]} :
      (ra == `RCFG_OFF_TXFREQ) ? {12'h0, txf} :
      (ra == `RCFG_OFF_RXFREQ) ? {12'h0, rxf} :
      (ra == `RCFG_OFF_RXDLY) ? {15'h0, rxdly[8], 8'h0, rxdly[7:0]} :
      (ra == `RCFG_OFF_RXIDLE) ? {15'h0, rxidle} :
      (ra == `RCFG_OFF_SKIP) ? (remote_na ? 32'h8000_0000 :
                                {16'h0, skip_digits}) :
      (ra == `RCFG_OFF_SLEEP) ? {31'h0, sleep} :
      (ra == `RCFG_OFF_UNIT) ? {16'h0, unit} :
      (ra == `RCFG_OFF_EXTADR) ? {27'h0, extadr} :
      (ra == `RCFG_OFF_PERMIT) ? permit :
      (ra == `RCFG_OFF_PRIM) ? {15'h0, prim[5], 11'h0, prim[4:0]} :
      (ra == `RCFG_OFF_ALARM) ? alarm_word : 32'h0000_0000;
   wire rd_acc = accept && !hwrite;

   // setup sequence: enter, key, release, quit, timeouts
   always_comb begin
      next_state = state;
      case (state)
         rcfg_pkg::RCFG_ST_NORMAL: begin
            if (cmd_wr && wd[`RCFG_CMD_SETUP]) begin
               next_state = rcfg_pkg::RCFG_ST_SETUP;
            end
         end
         rcfg_pkg::RCFG_ST_SETUP: begin
            if (cmd_wr && wd[`RCFG_CMD_KEY]) begin
               next_state = rcfg_pkg::RCFG_ST_KEYED;
            end
         end
         rcfg_pkg::RCFG_ST_KEYED: begin
            if ((cmd_wr && wd[`RCFG_CMD_RELEASE]) ||
                (minute && key_min == KEY_MIN - 8'h01)) begin
               next_state = rcfg_pkg::RCFG_ST_SETUP;
            end
         end
         default: next_state = rcfg_pkg::RCFG_ST_NORMAL;
      endcase
      if (in_setup && ((cmd_wr && wd[`RCFG_CMD_QUIT]) ||
          (minute && setup_min == SETUP_MIN - 8'h01))) begin
         next_state = rcfg_pkg::RCFG_ST_NORMAL;
      end
   end

   // bus phase capture and responses
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_valid <= 1'b0;
         ph_write <= 1'b0;
         ph_addr <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         ph_valid <= accept;
         ph_write <= hwrite;
         ph_addr <= haddr;
         hrdata <= rd_acc ? rd : 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // alarm pointer and write status
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         alarm_ptr <= 5'h00;
         rejected <= 1'b0;
      end else begin
         if (rd_acc && ra == `RCFG_OFF_ALARM) begin
            alarm_ptr <= found[5] ? after : 5'h00;
         end
         if (wr) begin
            rejected <= !write_ok;
         end
      end
   end

   // parameter registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         retry <= `RCFG_RETRY_RST;
         resp <= 8'h00;
         txf <= `RCFG_FREQ_RST;
         rxf <= `RCFG_FREQ_RST;
         rxdly <= 9'h000;
         rxidle <= 17'h00000;
         skip_digits <= 16'h0000;
         sleep <= 1'b0;
         unit <= 16'h0000;
         extadr <= 5'h00;
         permit <= 32'h0000_0000;
         prim <= 6'h00;
      end else if (do_wr) begin
         case (a)
            `RCFG_OFF_RETRY: retry <= wd[3:0];
            `RCFG_OFF_RESP: resp <= {wd[`RCFG_EN_BIT], wd[6:0]};
            `RCFG_OFF_TXFREQ: txf <= wd[19:0];
            `RCFG_OFF_RXFREQ: rxf <= wd[19:0];
            `RCFG_OFF_RXDLY: rxdly <= wd[`RCFG_EN_BIT] ?
               {1'b1, wd[7:0]} : 9'h000;
            `RCFG_OFF_RXIDLE: rxidle <= {wd[`RCFG_EN_BIT], 5'h00,
               wd[10:0]};
            `RCFG_OFF_SKIP: skip_digits <= wd[15:0];
            `RCFG_OFF_SLEEP: sleep <= wd[0];
            `RCFG_OFF_UNIT: unit <= wd[15:0];
            `RCFG_OFF_EXTADR: extadr <= wd[4:0];
            `RCFG_OFF_PERMIT: permit <= wd;
            `RCFG_OFF_PRIM: prim <= {wd[`RCFG_EN_BIT], wd[4:0]};
            default: ;
         endcase
      end
   end

   // zone strength store, refreshed by each sync message in the remote role
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < 8; i++) begin
            zone_loss[i] <= `RCFG_RSSI_WEAK;
         end
         rssi <= `RCFG_RSSI_WEAK;
      end else begin
         if (sync_msg && is_remote) begin
            zone_loss[sync_zone] <= sync_loss;
         end
         rssi <= clamp_loss;
      end
   end

   // minute prescaler and minute counters
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prescale <= 64'd0;
         idle_min <= 11'h000;
         setup_min <= 8'h00;
         key_min <= 8'h00;
         state <= rcfg_pkg::RCFG_ST_NORMAL;
      end else begin
         prescale <= minute ? 64'd0 : prescale + 64'd1;
         state <= next_state;
         if (rx_packet || !rxidle[`RCFG_EN_BIT]) begin
            idle_min <= 11'h000;
         end else if (minute && idle_min != 11'h7FF) begin
            idle_min <= idle_min + 11'h001;
         end
         if (!in_setup) begin
            setup_min <= 8'h00;
         end else if (minute) begin
            setup_min <= setup_min + 8'h01;
         end
         if (state != rcfg_pkg::RCFG_ST_KEYED) begin
            key_min <= 8'h00;
         end else if (minute) begin
            key_min <= key_min + 8'h01;
         end
      end
   end

   // alarm vector with the inactivity alarm merged at code 12
   always_comb begin
      alarm_vec = alarm_in;
      alarm_vec[12] = alarm_in[12] | rx_timeout_alarm;
   end

   // outputs to the radio, all registered
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         source_permitted <= 1'b0;
         hop_disable <= 1'b0;
         tx_key <= 1'b0;
         tx_freq_khz <= `RCFG_FREQ_RST;
         rx_freq_khz <= `RCFG_FREQ_RST;
         retry_count <= `RCFG_RETRY_RST;
         retry_enable <= 1'b1;
         rxd_delay_ms <= 8'h00;
         skip_mask <= 8'h00;
         sleep_enable <= 1'b0;
         responder_addr <= 8'h00;
         responder_on <= 1'b0;
         rx_timeout_alarm <= 1'b0;
      end else begin
         source_permitted <= permit[source_addr] ||
            (prim[5] && source_addr == prim[4:0]);
         hop_disable <= in_setup;
         tx_key <= next_state == rcfg_pkg::RCFG_ST_KEYED;
         tx_freq_khz <= txf;
         rx_freq_khz <= rxf;
         retry_count <= retry;
         retry_enable <= retry != 4'h0;
         rxd_delay_ms <= rxdly[8] ? rxdly[7:0] : 8'h00;
         skip_mask <= next_skip_mask;
         sleep_enable <= sleep && is_remote;
         responder_addr <= {1'b0, resp[6:0]};
         responder_on <= resp[7];
         rx_timeout_alarm <= rxidle[`RCFG_EN_BIT] && !rx_packet &&
            idle_min >= rxidle[10:0];
      end
   end
endmodule // rcfg_top
`default_nettype wire

// ### rcfg_top_properties.sv
// Purpose: concurrent checks on the rcfg_top ports
// Assumes: bound to rcfg_top from the testbench top file
// Notes: keyed and setup spans are counted in helper counters
`timescale 1ns/1ps
`default_nettype none
`include "rcfg_params.svh"
module rcfg_top_properties #(
   parameter logic [63:0] MINUTE_CYCLES = 64'd20
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [1:0] role,
   input wire logic hop_disable,
   input wire logic tx_key,
   input wire logic [19:0] tx_freq_khz,
   input wire logic [3:0] retry_count,
   input wire logic retry_enable,
   input wire logic [7:0] rxd_delay_ms,
   input wire logic [7:0] skip_mask,
   input wire logic sleep_enable,
   input wire logic [7:0] responder_addr,
   input wire logic rx_timeout_alarm
);
   logic [63:0] key_cnt;
   logic [63:0] setup_cnt;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // run lengths of keyed and setup spans
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         key_cnt <= 64'h0;
         setup_cnt <= 64'h0;
      end else begin
         key_cnt <= tx_key ? key_cnt + 64'h1 : 64'h0;
         setup_cnt <= hop_disable ? setup_cnt + 64'h1 : 64'h0;
      end
   end
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   a_retry_range: assert property (retry_count <= `RCFG_RETRY_MAX)
      else $error("retry count above ten");
   a_retry_zero: assert property (retry_enable == (retry_count != 4'h0))
      else $error("retry enable disagrees with count");
   a_sleep_role: assert property (sleep_enable && $stable(role) |->
      role != 2'h1 && role != 2'h2)
      else $error("sleep on for master or extension");
   a_freq_range: assert property (tx_freq_khz >= `RCFG_FREQ_MIN &&
      tx_freq_khz <= `RCFG_FREQ_MAX)
      else $error("transmit test frequency out of band");
   a_delay_range: assert property (rxd_delay_ms <= `RCFG_RXDLY_MAX)
      else $error("receive delay above limit");
   a_skip_four: assert property ($countones(skip_mask) <= 4)
      else $error("more than four zones skipped");
   a_resp_range: assert property (responder_addr <= 8'h50)
      else $error("responder address above limit");
   a_key_setup: assert property ($fell(hop_disable) |-> !tx_key [*2])
      else $error("transmitter keyed outside setup");
   a_key_release: assert property (key_cnt <= 5 * MINUTE_CYCLES + 2)
      else $error("keyed transmitter not released");
   a_setup_limit: assert property (setup_cnt <= 10 * MINUTE_CYCLES + 2)
      else $error("setup mode held too long");
   c_keyed: cover property ($fell(tx_key) && hop_disable);
   c_setup_end: cover property ($fell(hop_disable));
   c_alarm: cover property ($rose(rx_timeout_alarm));
endmodule // rcfg_top_properties
`default_nettype wire

// ### rcfg_host_model.sv
// Purpose: operator side host issuing AHB-Lite single word transfers
// Assumes: one slave whose hreadyout is the bus hready
// Notes: signals change by non-blocking assignment after a rising edge
`timescale 1ns/1ps
`default_nettype none
module rcfg_host_model (
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [7:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   // bus idle from time zero
   initial begin
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // address phase, then data phase, each held until hready
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask
endmodule // rcfg_host_model
`default_nettype wire

// ### test_radio_config_test_controller.sv
// Purpose: self-checking bench for rcfg_top
// Assumes: zero wait state slave, one minute shortened to 20 cycles
// Notes: the host model carries every register transfer
`timescale 1ns/1ps
`default_nettype none
`include "rcfg_params.svh"
`define CHK(n, e, g) begin \
   num_checks++; \
   if ((g) !== (e)) begin \
      miscompares++; \
      $display("CHECK FAILED %s expected %h seen %h", n, e, g); \
   end \
end
module test_radio_config_test_controller;
   localparam logic [63:0] MIN_C = 64'd20;
   localparam logic [31:0] NA = 32'h8000_0000;
   localparam logic [31:0] EN = 32'h0001_0000;
   int miscompares = 0;
   int num_checks = 0;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel, hwrite, hreadyout, hresp, source_permitted, hop_disable;
   logic tx_key, retry_enable, sleep_enable, responder_on, rx_timeout_alarm;
   logic [7:0] haddr, rxd_delay_ms, skip_mask, responder_addr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, q;
   logic [19:0] tx_freq_khz, rx_freq_khz;
   logic [3:0] retry_count;
   logic [1:0] role = 2'h1;
   logic dependent = 1'b0;
   logic synced = 1'b0;
   logic sync_msg = 1'b0;
   logic rx_packet = 1'b0;
   logic [2:0] sync_zone = 3'h0;
   logic [7:0] sync_loss = 8'h00;
   logic [7:0] raw_loss = 8'h14;
   logic [31:0] alarm_in = 32'h0;
   logic [4:0] source_addr = 5'h00;
   // free-running 200 MHz clock
   always #2.5 hclk = ~hclk;
   rcfg_host_model u_host (.hclk, .hready(hreadyout), .hrdata, .hsel,
      .haddr, .htrans, .hwrite, .hsize, .hwdata);
   rcfg_top #(.MINUTE_CYCLES(MIN_C)) u_dut (.hclk, .hresetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp, .role, .dependent, .synced, .sync_msg, .sync_zone,
      .sync_loss, .raw_loss, .rx_packet, .alarm_in, .source_addr,
      .source_permitted, .hop_disable, .tx_key, .tx_freq_khz, .rx_freq_khz,
      .retry_count, .retry_enable, .rxd_delay_ms, .skip_mask, .sleep_enable,
      .responder_addr, .responder_on, .rx_timeout_alarm);
   // bus and stimulus helpers
   task automatic wait_c(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      u_host.xfer(1'b1, a, d, r);
      wait_c(1);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e,
      input string n);
      logic [31:0] r;
      u_host.xfer(1'b0, a, 32'h0, r);
      `CHK(n, e, r)
   endtask
   task automatic sync8(input logic [7:0] l);
      for (int i = 0; i < 8; i++) begin
         @(posedge hclk);
         sync_msg <= 1'b1;
         sync_zone <= 3'(i);
         sync_loss <= l + 8'(2 * i);
      end
      @(posedge hclk);
      sync_msg <= 1'b0;
   endtask
   task automatic perm(input logic [4:0] a, input logic e);
      @(posedge hclk);
      source_addr <= a;
      wait_c(1);
      `CHK("perm", e, source_permitted)
   endtask
   task automatic results();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // hang guard, well beyond the expected run
   initial begin
      #100000;
      miscompares++;
      results();
   end
   // main sequence, master role first
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      wait_c(1);
      `CHK("retry", 4'hA, retry_count)
      `CHK("txf", `RCFG_FREQ_RST, tx_freq_khz)
      `CHK("ron", 1'b0, responder_on)
      `CHK("alarm", 1'b0, rx_timeout_alarm)
      wr(`RCFG_OFF_RETRY, 32'h0);
      `CHK("ren", 1'b0, retry_enable)
      wr(`RCFG_OFF_RETRY, 32'hB);
      rchk(`RCFG_OFF_RETRY, 32'h0, "rty");
      rchk(`RCFG_OFF_STATUS, 32'h10, "stat");
      wr(`RCFG_OFF_RETRY, 32'hA);
      rchk(`RCFG_OFF_RSSI, NA, "rssi");
      wr(`RCFG_OFF_SLEEP, 32'h1);
      `CHK("sleep", 1'b0, sleep_enable)
      wr(`RCFG_OFF_SKIP, 32'h1358);
      wr(`RCFG_OFF_SKIP, 32'h9000);
      `CHK("skip", 8'h95, skip_mask)
      wr(`RCFG_OFF_EXTADR, 32'h1F);
      wr(8'h40, 32'hFFFF_FFFF);
      rchk(8'h40, 32'h0, "unmap");
      wr(`RCFG_OFF_TXFREQ, 32'hDC438);
      wr(`RCFG_OFF_TXFREQ, 32'hE2839);
      wr(`RCFG_OFF_RXFREQ, 32'hE2838);
      wr(`RCFG_OFF_RXFREQ, 32'hDC437);
      `CHK("txf", 20'hDC438, tx_freq_khz)
      `CHK("rxf", 20'hE2838, rx_freq_khz)
      wr(`RCFG_OFF_RXDLY, EN | 32'hEB);
      wr(`RCFG_OFF_RXDLY, EN | 32'hEC);
      `CHK("dly", 8'hEB, rxd_delay_ms)
      wr(`RCFG_OFF_RXDLY, 32'h0);
      rchk(`RCFG_OFF_RXDLY, 32'h0, "dly");
      wr(`RCFG_OFF_UNIT, 32'h270F);
      rchk(`RCFG_OFF_UNIT, 32'h0, "unit");
      wr(`RCFG_OFF_UNIT, 32'hFDE8);
      wr(`RCFG_OFF_UNIT, 32'hFDE9);
      rchk(`RCFG_OFF_UNIT, 32'hFDE8, "unit");
      wr(`RCFG_OFF_RESP, EN | 32'h50);
      wr(`RCFG_OFF_RESP, EN | 32'h51);
      `CHK("raddr", 8'h50, responder_addr)
      `CHK("ron", 1'b1, responder_on)
      // setup mode, keying and both timers
      wr(`RCFG_OFF_CMD, 32'h1);
      `CHK("hop", 1'b1, hop_disable)
      rchk(`RCFG_OFF_RSSI, 32'h28, "rssi");
      wr(`RCFG_OFF_CMD, 32'h4);
      `CHK("key", 1'b1, tx_key)
      wr(`RCFG_OFF_CMD, 32'h8);
      `CHK("key", 1'b0, tx_key)
      wr(`RCFG_OFF_CMD, 32'h4);
      wait_c(110);
      `CHK("key", 1'b0, tx_key)
      `CHK("hop", 1'b1, hop_disable)
      wr(`RCFG_OFF_CMD, 32'h2);
      `CHK("hop", 1'b0, hop_disable)
      wr(`RCFG_OFF_CMD, 32'h4);
      `CHK("key", 1'b0, tx_key)
      wr(`RCFG_OFF_CMD, 32'h1);
      wait_c(150);
      `CHK("hop", 1'b1, hop_disable)
      wait_c(65);
      `CHK("hop", 1'b0, hop_disable)
      // remote role
      @(posedge hclk);
      role <= 2'h0;
      wr(`RCFG_OFF_RETRY, 32'h3);
      rchk(`RCFG_OFF_RETRY, NA, "rty");
      wr(`RCFG_OFF_SKIP, 32'h0);
      rchk(`RCFG_OFF_SKIP, NA, "skip");
      `CHK("skip", 8'h95, skip_mask)
      wr(`RCFG_OFF_EXTADR, 32'h3);
      @(posedge hclk);
      synced <= 1'b1;
      rchk(`RCFG_OFF_RETRY, 32'hA, "rty");
      rchk(`RCFG_OFF_EXTADR, 32'h1F, "xad");
      sync8(8'h1E);
      rchk(`RCFG_OFF_RSSI, 32'h28, "rssi");
      sync8(8'h46);
      rchk(`RCFG_OFF_RSSI, 32'h4D, "rssi");
      wr(`RCFG_OFF_SLEEP, 32'h1);
      `CHK("sleep", 1'b1, sleep_enable)
      // dependent master
      @(posedge hclk);
      role <= 2'h1;
      dependent <= 1'b1;
      synced <= 1'b0;
      wait_c(2);
      `CHK("sleep", 1'b0, sleep_enable)
      rchk(`RCFG_OFF_RSSI, NA, "rssi");
      synced <= 1'b1;
      rchk(`RCFG_OFF_RSSI, 32'h4D, "rssi");
      // synchronization source filter
      wr(`RCFG_OFF_PERMIT, 32'h8000_0001);
      perm(5'h00, 1'b1);
      perm(5'h1F, 1'b1);
      perm(5'h05, 1'b0);
      wr(`RCFG_OFF_PRIM, EN | 32'h5);
      perm(5'h05, 1'b1);
      wr(`RCFG_OFF_PRIM, 32'h0);
      perm(5'h05, 1'b0);
      // inactivity alarm and alarm report
      wr(`RCFG_OFF_RXIDLE, EN | 32'h1);
      wait_c(45);
      `CHK("alarm", 1'b1, rx_timeout_alarm)
      @(posedge hclk);
      rx_packet <= 1'b1;
      @(posedge hclk);
      rx_packet <= 1'b0;
      wait_c(1);
      `CHK("alarm", 1'b0, rx_timeout_alarm)
      wr(`RCFG_OFF_RXIDLE, 32'h0);
      wait_c(45);
      `CHK("alarm", 1'b0, rx_timeout_alarm)
      rchk(`RCFG_OFF_ALARM, 32'h0, "stat");
      @(posedge hclk);
      alarm_in <= 32'h0001_0002;
      rchk(`RCFG_OFF_ALARM, 32'h8000_0301, "stat");
      u_host.xfer(1'b0, `RCFG_OFF_ALARM, 32'h0, q);
      `CHK("stat", 32'h8000_0010, q & 32'h8000_011F)
      results();
   end
endmodule // test_radio_config_test_controller
bind rcfg_top rcfg_top_properties #(.MINUTE_CYCLES(MINUTE_CYCLES)) u_props (
   .hclk, .hresetn, .hreadyout, .hresp, .role, .hop_disable, .tx_key,
   .tx_freq_khz, .retry_count, .retry_enable, .rxd_delay_ms, .skip_mask,
   .sleep_enable, .responder_addr, .rx_timeout_alarm);
`default_nettype wire
